// *** rtl/cpcs_byte_if.sv ***
/*
  byte stream between the frame handler and the serial line module.
  assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cpcs_byte_if;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  modport line (output rx_data, output rx_valid, input tx_data, input tx_valid, output tx_ready);
  modport frame (input rx_data, input rx_valid, output tx_data, output tx_valid, input tx_ready);
endinterface : cpcs_byte_if
`default_nettype wire

// *** rtl/cpcs_pkg.sv ***
/*
  constants of the camera parameter command set: frame bytes, command codes,
  field positions, reset values, value limits and serial timing.
  assumes a single 25 MHz system clock.
*/
`default_nettype none
package cpcs_pkg;
  // frame delimiters
  localparam logic [7:0] CPCS_START_BYTE = 8'h02;
  localparam logic [7:0] CPCS_END_BYTE   = 8'h03;
  localparam int         CPCS_RW_BIT     = 7;
  // command codes
  localparam logic [7:0] CPCS_CMD_FEATURE = 8'h91;
  localparam logic [7:0] CPCS_CMD_GRAY    = 8'h98;
  localparam logic [7:0] CPCS_CMD_STAMP   = 8'h99;
  localparam logic [7:0] CPCS_CMD_TEST    = 8'ha1;
  localparam logic [7:0] CPCS_CMD_SHIFT   = 8'ha5;
  localparam logic [7:0] CPCS_CMD_LINE    = 8'ha8;
  localparam logic [7:0] CPCS_CMD_COLUMN  = 8'ha9;
  localparam logic [7:0] CPCS_CMD_HEIGHT  = 8'haa;
  localparam logic [7:0] CPCS_CMD_WIDTH   = 8'hab;
  localparam logic [7:0] CPCS_CMD_STROBE  = 8'hac;
  // field positions
  localparam int CPCS_DARK_BIT       = 0;
  localparam int CPCS_SHUTTER_BIT    = 4;
  localparam int CPCS_STAMP_BIT      = 7;
  localparam int CPCS_DYNAMIC_BIT    = 6;
  localparam int CPCS_LOW_SIDE_BIT   = 4;
  localparam int CPCS_HIGH_SIDE_BIT  = 5;
  // reset values
  localparam logic [7:0]  CPCS_GRAY_RESET   = 8'h0c;
  localparam logic [7:0]  CPCS_BYTE_RESET   = 8'h00;
  localparam logic [15:0] CPCS_WIDTH_RESET  = 16'h0500;
  localparam logic [15:0] CPCS_HEIGHT_RESET = 16'h0400;
  localparam logic [15:0] CPCS_WORD_RESET   = 16'h0000;
  // value limits
  localparam logic [15:0] CPCS_COLUMN_MAX = 16'h04f6;
  localparam logic [15:0] CPCS_WIDTH_MIN  = 16'h000a;
  localparam logic [15:0] CPCS_WIDTH_MAX  = 16'h0500;
  localparam logic [15:0] CPCS_LINE_MAX   = 16'h03ff;
  localparam logic [15:0] CPCS_HEIGHT_MIN = 16'h0002;
  localparam logic [15:0] CPCS_HEIGHT_MAX = 16'h0400;
  localparam logic [7:0]  CPCS_SHIFT_MAX  = 8'h03;
  localparam logic [7:0]  CPCS_TEST_MAX   = 8'h04;
  // strobe base modes
  localparam logic [3:0] CPCS_STB_LOW      = 4'h0;
  localparam logic [3:0] CPCS_STB_EXPOSE   = 4'h1;
  localparam logic [3:0] CPCS_STB_EXT      = 4'h2;
  localparam logic [3:0] CPCS_STB_HIGH     = 4'h3;
  localparam logic [3:0] CPCS_STB_EXPOSE_N = 4'h5;
  localparam logic [3:0] CPCS_STB_EXT_N    = 4'h6;
  // serial timing
  localparam int CPCS_CLK_HZ     = 25_000_000;
  localparam int CPCS_BAUD       = 500_000;
  localparam int CPCS_BIT_CYCLES = CPCS_CLK_HZ / CPCS_BAUD;
  localparam int CPCS_MAX_DATA   = 3;

  // data length each command carries, zero for an unknown code
  function automatic logic [6:0] cpcs_cmd_len(input logic [7:0] code);
    case (code)
      CPCS_CMD_GRAY: cpcs_cmd_len = 7'd3;
      CPCS_CMD_LINE, CPCS_CMD_COLUMN, CPCS_CMD_HEIGHT, CPCS_CMD_WIDTH: cpcs_cmd_len = 7'd2;
      CPCS_CMD_FEATURE, CPCS_CMD_STAMP, CPCS_CMD_TEST, CPCS_CMD_SHIFT, CPCS_CMD_STROBE: cpcs_cmd_len = 7'd1;
      default: cpcs_cmd_len = 7'd0;
    endcase
  endfunction : cpcs_cmd_len
endpackage : cpcs_pkg
`default_nettype wire

// *** rtl/cpcs_serial.sv ***
/*
  8N1 serial receiver and transmitter, lsb first.
  assumes the receive pin is asynchronous; it is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module cpcs_serial
  import cpcs_pkg::*;
(
  input  wire logic sys_clk,   // system clock
  input  wire logic rst_n,     // async reset, active low
  input  wire logic rx_pin,    // serial receive pin
  output var  logic tx_pin,    // serial transmit pin
  cpcs_byte_if.line bytes      // byte stream to frame handler
);
  logic [1:0]  rx_sync_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [8:0]  rx_shift_reg;
  logic        rx_busy_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_valid_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_shift_reg;
  logic        tx_pin_reg;

  // two-stage synchroniser on the receive pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rx_sync_reg <= 2'b11;
    else rx_sync_reg <= {rx_sync_reg[0], rx_pin};
  end

  // receiver: start edge, centre sampling of 9 bits after the start bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_busy_reg  <= 1'b0;
      rx_data_reg  <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_sync_reg[1]) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= 16'(CPCS_BIT_CYCLES / 2);
          rx_bit_reg  <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= 16'(CPCS_BIT_CYCLES - 1);
        if (rx_bit_reg == 4'h0 && rx_sync_reg[1]) begin
          rx_busy_reg <= 1'b0;                           // false start
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_data_reg <= rx_shift_reg[8:1];
          rx_valid_reg <= rx_sync_reg[1];                // stop bit must be high
        end else begin
          rx_bit_reg <= rx_bit_reg + 4'h1;
          rx_shift_reg <= {rx_sync_reg[1], rx_shift_reg[8:1]};
        end
      end
    end
  end

  // transmitter: shifts start, data and stop bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_reg   <= 16'h0000;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 10'h3ff;
      tx_pin_reg   <= 1'b1;
    end else if (tx_bit_reg == 4'h0) begin
      tx_pin_reg <= 1'b1;
      if (bytes.tx_valid) begin
        tx_shift_reg <= {1'b1, bytes.tx_data, 1'b0};
        tx_bit_reg   <= 4'hb;
        tx_cnt_reg   <= 16'h0000;
      end
    end else if (tx_cnt_reg != 16'h0000) begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end else begin
      tx_cnt_reg   <= 16'(CPCS_BIT_CYCLES - 1);
      tx_pin_reg   <= tx_shift_reg[0];
      tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
      tx_bit_reg   <= tx_bit_reg - 4'h1;
    end
  end

  assign bytes.rx_data  = rx_data_reg;
  assign bytes.rx_valid = rx_valid_reg;
  assign bytes.tx_ready = (tx_bit_reg == 4'h0);
  assign tx_pin         = tx_pin_reg;
endmodule : cpcs_serial
`default_nettype wire

// *** rtl/cpcs_top.sv ***
/*
  camera parameter command handler: parses serial frames, stores settings,
  answers reads, and applies the settings to strobe, pixel and region outputs.
  assumes one 25 MHz clock; the serial and strobe source pins are synchronised here, the pixel inputs are not.
*/
// Behaviour
// [R1] feature byte: bit 0 dark-signal constancy, bit 4 shutterline correction
// [R2] gray byte is added to each 10-bit pixel; bytes two and three zero; code adds it only while feature bit 4 (shutterline correction) is set
// [R3] gray value 0 to 255, holds 12 after reset
// [R4] shift codes 0 to 3 shift the output pixel left
// [R5] start column arrives low byte first, then high byte
// [R6] host writes start column 0 to 0x04f6 in steps of 10; code checks only the range and accepts any column up to 0x04f6
// [R7] readout begins at start column setting plus one
// [R8] host writes width 0x000a to 0x0500, low byte first
// [R9] host writes start line 0 to 0x03ff, low byte first
// [R10] host writes height 0x0002 to 0x0400, low byte first
// [R11] stamp byte: bit 7 region stamp, bit 6 dynamic region
// [R12] strobe base modes low, exposure, external, high and the two inverses
// [R13] 0x10 adds low-side driver, 0x20 high-side driver
// [R14] host never sets both driver options together
// [R15] test image source codes 0 to 4
// [R16] frames start with 0x02 and end with 0x03
// [R17] descriptor byte two: read flag in msb, length below
// [R18] check byte is xor of descriptor and data bytes
// [R19] reads answer with code, flag clear, length, current value; writes silent
// [R20] invalid check, length or value leaves settings unchanged
`timescale 1ns/1ps
`default_nettype none
module cpcs_top
  import cpcs_pkg::*;
(
  input  wire logic        sys_clk,            // system clock, 25 MHz
  input  wire logic        rst_n,              // async reset, active low
  input  wire logic        serial_rx,          // serial command input pin
  output var  logic        serial_tx,          // serial reply output pin
  input  wire logic        exposure_active,    // exposure window pin
  input  wire logic        external_strobe_input, // strobe request from grabber
  input  wire logic [9:0]  pixel_in,           // raw pixel
  input  wire logic        pixel_in_valid,     // raw pixel valid
  output logic      [13:0] pixel_out,          // corrected, shifted pixel
  output logic             pixel_out_valid,    // pixel_out valid
  output logic             strobe_output,      // strobe level
  output logic             strobe_low_side_en, // open-collector driver select
  output logic             strobe_high_side_en,// high-side driver select
  output logic             dark_signal_constancy_en, // dark-signal correction on
  output logic             region_stamp_en,    // region stamp on
  output logic             dynamic_region_en,  // dynamic region on
  output logic      [7:0]  test_image_sel,     // image source
  output logic      [15:0] region_first_column,// first readout column
  output logic      [15:0] region_width,       // width in columns
  output logic      [15:0] region_first_line,  // first readout line
  output logic      [15:0] region_height       // height in lines
);
  typedef enum logic [2:0] {S_IDLE, S_CODE, S_LEN, S_DATA, S_CHECK, S_END, S_EXEC, S_REPLY} cpcs_state_type;

  cpcs_byte_if bytes ();
  cpcs_state_type state_reg;
  logic [7:0]  code_reg;
  logic        read_reg;
  logic [6:0]  len_reg;
  logic [6:0]  cnt_reg;
  logic [23:0] data_reg;
  logic [7:0]  bcc_reg;
  logic        bcc_ok_reg;
  logic [7:0]  feature_reg, gray_reg, stamp_reg, test_reg, shift_reg, strobe_reg;
  logic [15:0] line_reg, column_reg, height_reg, width_reg;
  logic [1:0]  expo_sync_reg, ext_sync_reg;
  logic [7:0]  tx_data_reg;
  logic        tx_valid_reg;
  logic        len_ok, value_ok, do_write;
  logic [23:0] read_value;
  logic [7:0]  reply_byte, reply_bcc;
  logic        strobe_next;
  logic [10:0] pixel_sum;

  cpcs_serial u_serial (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .rx_pin  (serial_rx),
    .tx_pin  (serial_tx),
    .bytes   (bytes)
  );

  // frame checks: known code and matching length, value within range
  assign len_ok = (cpcs_cmd_len(code_reg) != 7'd0) && (cpcs_cmd_len(code_reg) == len_reg);
  always_comb begin
    case (code_reg)
      CPCS_CMD_FEATURE: value_ok = (data_reg[7:0] & 8'hee) == 8'h00;                      // see [R1]
      CPCS_CMD_GRAY:    value_ok = data_reg[23:8] == 16'h0000;                            // see [R2] see [R3]
      CPCS_CMD_SHIFT:   value_ok = data_reg[7:0] <= CPCS_SHIFT_MAX;                       // see [R4]
      CPCS_CMD_COLUMN:  value_ok = data_reg[15:0] <= CPCS_COLUMN_MAX;
      CPCS_CMD_WIDTH:   value_ok = data_reg[15:0] >= CPCS_WIDTH_MIN && data_reg[15:0] <= CPCS_WIDTH_MAX;
      CPCS_CMD_LINE:    value_ok = data_reg[15:0] <= CPCS_LINE_MAX;
      CPCS_CMD_HEIGHT:  value_ok = data_reg[15:0] >= CPCS_HEIGHT_MIN && data_reg[15:0] <= CPCS_HEIGHT_MAX;
      CPCS_CMD_STAMP:   value_ok = (data_reg[7:0] & 8'h3f) == 8'h00;                      // see [R11]
      CPCS_CMD_TEST:    value_ok = data_reg[7:0] <= CPCS_TEST_MAX;                        // see [R15]
      CPCS_CMD_STROBE:  value_ok = (data_reg[7:6] == 2'b00) && !(data_reg[5] && data_reg[4]) &&
                                   (data_reg[3:0] <= CPCS_STB_HIGH || data_reg[3:0] == CPCS_STB_EXPOSE_N ||
                                    data_reg[3:0] == CPCS_STB_EXT_N);                    // see [R12] see [R13]
      default:          value_ok = 1'b0;
    endcase
  end
  assign do_write = (state_reg == S_EXEC) && !read_reg && bcc_ok_reg && len_ok && value_ok; // see [R20]

  // frame parser and reply sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= S_IDLE;
      code_reg   <= 8'h00;
      read_reg   <= 1'b0;
      len_reg    <= 7'd0;
      cnt_reg    <= 7'd0;
      data_reg   <= 24'h000000;
      bcc_reg    <= 8'h00;
      bcc_ok_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: if (bytes.rx_valid && bytes.rx_data == CPCS_START_BYTE) begin  // see [R16]
          state_reg <= S_CODE;
        end
        S_CODE: if (bytes.rx_valid) begin
          code_reg  <= bytes.rx_data;
          bcc_reg   <= bytes.rx_data;
          data_reg  <= 24'h000000;
          cnt_reg   <= 7'd0;
          state_reg <= S_LEN;
        end
        S_LEN: if (bytes.rx_valid) begin
          read_reg  <= bytes.rx_data[CPCS_RW_BIT];                            // see [R17]
          len_reg   <= bytes.rx_data[6:0];
          bcc_reg   <= bcc_reg ^ bytes.rx_data;
          state_reg <= (bytes.rx_data[CPCS_RW_BIT] || bytes.rx_data[6:0] == 7'd0) ? S_CHECK : S_DATA;
        end
        S_DATA: if (bytes.rx_valid) begin
          if (cnt_reg < 7'(CPCS_MAX_DATA)) begin
            data_reg[8*cnt_reg[1:0] +: 8] <= bytes.rx_data;                  // low byte first, see [R5]
          end
          bcc_reg <= bcc_reg ^ bytes.rx_data;
          cnt_reg <= cnt_reg + 7'd1;
          if (cnt_reg + 7'd1 == len_reg) state_reg <= S_CHECK;
        end
        S_CHECK: if (bytes.rx_valid) begin
          bcc_ok_reg <= (bytes.rx_data == bcc_reg);                           // see [R18]
          state_reg  <= S_END;
        end
        S_END: if (bytes.rx_valid) begin
          state_reg <= (bytes.rx_data == CPCS_END_BYTE) ? S_EXEC : S_IDLE;    // see [R16]
        end
        S_EXEC: begin
          cnt_reg   <= 7'd0;
          state_reg <= (read_reg && bcc_ok_reg && len_ok) ? S_REPLY : S_IDLE; // see [R19]
        end
        S_REPLY: if (tx_valid_reg && bytes.tx_ready) begin
          cnt_reg <= cnt_reg + 7'd1;
          if (cnt_reg == len_reg + 7'd4) state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // current value of the addressed setting, low byte first
  always_comb begin
    case (code_reg)
      CPCS_CMD_FEATURE: read_value = {16'h0000, feature_reg};
      CPCS_CMD_GRAY:    read_value = {16'h0000, gray_reg};
      CPCS_CMD_STAMP:   read_value = {16'h0000, stamp_reg};
      CPCS_CMD_TEST:    read_value = {16'h0000, test_reg};
      CPCS_CMD_SHIFT:   read_value = {16'h0000, shift_reg};
      CPCS_CMD_STROBE:  read_value = {16'h0000, strobe_reg};
      CPCS_CMD_LINE:    read_value = {8'h00, line_reg};
      CPCS_CMD_COLUMN:  read_value = {8'h00, column_reg};
      CPCS_CMD_HEIGHT:  read_value = {8'h00, height_reg};
      CPCS_CMD_WIDTH:   read_value = {8'h00, width_reg};
      default:          read_value = 24'h000000;
    endcase
  end

  // reply frame: start, code, length with flag clear, data, check, end
  assign reply_bcc = code_reg ^ {1'b0, len_reg} ^ read_value[7:0] ^ read_value[15:8] ^ read_value[23:16];
  always_comb begin
    if (cnt_reg == 7'd0) reply_byte = CPCS_START_BYTE;
    else if (cnt_reg == 7'd1) reply_byte = code_reg;
    else if (cnt_reg == 7'd2) reply_byte = {1'b0, len_reg};                  // see [R19]
    else if (cnt_reg < len_reg + 7'd3) reply_byte = read_value[8*(cnt_reg - 7'd3) +: 8];
    else if (cnt_reg == len_reg + 7'd3) reply_byte = reply_bcc;             // see [R18]
    else reply_byte = CPCS_END_BYTE;
  end

  // transmit holding stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end else if (tx_valid_reg) begin
      if (bytes.tx_ready) tx_valid_reg <= 1'b0;
    end else if (state_reg == S_REPLY && !(tx_valid_reg && bytes.tx_ready)) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg  <= reply_byte;
    end
  end
  assign bytes.tx_data  = tx_data_reg;
  assign bytes.tx_valid = tx_valid_reg;

  // settings store; a rejected frame leaves every setting as it was
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_reg <= CPCS_BYTE_RESET;
      gray_reg    <= CPCS_GRAY_RESET;                                         // see [R3]
      stamp_reg   <= CPCS_BYTE_RESET;
      test_reg    <= CPCS_BYTE_RESET;
      shift_reg   <= CPCS_BYTE_RESET;
      strobe_reg  <= CPCS_BYTE_RESET;
      line_reg    <= CPCS_WORD_RESET;
      column_reg  <= CPCS_WORD_RESET;
      height_reg  <= CPCS_HEIGHT_RESET;
      width_reg   <= CPCS_WIDTH_RESET;
    end else if (do_write) begin
      case (code_reg)
        CPCS_CMD_FEATURE: feature_reg <= data_reg[7:0];
        CPCS_CMD_GRAY:    gray_reg    <= data_reg[7:0];
        CPCS_CMD_STAMP:   stamp_reg   <= data_reg[7:0];
        CPCS_CMD_TEST:    test_reg    <= data_reg[7:0];
        CPCS_CMD_SHIFT:   shift_reg   <= data_reg[7:0];
        CPCS_CMD_STROBE:  strobe_reg  <= data_reg[7:0];
        CPCS_CMD_LINE:    line_reg    <= data_reg[15:0];
        CPCS_CMD_COLUMN:  column_reg  <= data_reg[15:0];                     // see [R5]
        CPCS_CMD_HEIGHT:  height_reg  <= data_reg[15:0];
        CPCS_CMD_WIDTH:   width_reg   <= data_reg[15:0];
        default:          feature_reg <= feature_reg;
      endcase
    end
  end

  // synchronisers for the strobe source pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expo_sync_reg <= 2'b00;
      ext_sync_reg  <= 2'b00;
    end else begin
      expo_sync_reg <= {expo_sync_reg[0], exposure_active};
      ext_sync_reg  <= {ext_sync_reg[0], external_strobe_input};
    end
  end

  // strobe level from the base mode
  always_comb begin
    case (strobe_reg[3:0])
      CPCS_STB_EXPOSE:   strobe_next = expo_sync_reg[1];                      // see [R12]
      CPCS_STB_EXT:      strobe_next = ext_sync_reg[1];
      CPCS_STB_HIGH:     strobe_next = 1'b1;
      CPCS_STB_EXPOSE_N: strobe_next = !expo_sync_reg[1];
      CPCS_STB_EXT_N:    strobe_next = !ext_sync_reg[1];
      default:           strobe_next = 1'b0;
    endcase
  end

  // gray add when shutterline correction is on, then digital shift
  assign pixel_sum = {1'b0, pixel_in} + (feature_reg[CPCS_SHUTTER_BIT] ? {3'b000, gray_reg} : 11'h000); // see [R2]

  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_out                <= 14'h0000;
      pixel_out_valid          <= 1'b0;
      strobe_output            <= 1'b0;
      strobe_low_side_en       <= 1'b0;
      strobe_high_side_en      <= 1'b0;
      dark_signal_constancy_en <= 1'b0;
      region_stamp_en          <= 1'b0;
      dynamic_region_en        <= 1'b0;
      test_image_sel           <= 8'h00;
      region_first_column      <= 16'h0000;
      region_width             <= 16'h0000;
      region_first_line        <= 16'h0000;
      region_height            <= 16'h0000;
    end else begin
      pixel_out                <= {3'b000, pixel_sum} << shift_reg[1:0];     // see [R4]
      pixel_out_valid          <= pixel_in_valid;
      strobe_output            <= strobe_next;
      strobe_low_side_en       <= strobe_reg[CPCS_LOW_SIDE_BIT];             // see [R13]
      strobe_high_side_en      <= strobe_reg[CPCS_HIGH_SIDE_BIT];
      dark_signal_constancy_en <= feature_reg[CPCS_DARK_BIT];                // see [R1]
      region_stamp_en          <= stamp_reg[CPCS_STAMP_BIT];                 // see [R11]
      dynamic_region_en        <= stamp_reg[CPCS_DYNAMIC_BIT];
      test_image_sel           <= test_reg;                                  // see [R15]
      region_first_column      <= column_reg + 16'h0001;                     // see [R7]
      region_width             <= width_reg;
      region_first_line        <= line_reg + 16'h0001;
      region_height            <= height_reg;
    end
  end
endmodule : cpcs_top
`default_nettype wire

// *** tb/cpcs_host.sv ***
/*
  host model: sends framed commands and receives reply bytes, 8N1 lsb first.
  assumes the bit time of the package and a line idle at mark level.
*/
`timescale 1ns/1ps
`default_nettype none
module cpcs_host
  import cpcs_pkg::*;
(
  input  wire logic sys_clk,   // system clock
  output var  logic serial_rx, // line to the camera
  input  wire logic serial_tx  // line from the camera
);
  initial serial_rx = 1'b1; // mark level while idle
  // one character: start, eight bits lsb first, stop
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk) serial_rx <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
      repeat (CPCS_BIT_CYCLES - 1) @(negedge sys_clk);
    end
  endtask : put
  // start, descriptor, data low byte first, check byte, end
  task automatic frame(input logic [7:0] code, input logic [7:0] desc, input logic [23:0] data,
                       input logic [7:0] flip);
    logic [7:0] bcc;
    bcc = code ^ desc ^ flip;
    put(CPCS_START_BYTE);
    put(code);
    put(desc);
    for (int i = 0; i < 3; i++) if (!desc[7] && i < int'(desc[6:0])) begin
      put(data[8*i +: 8]);
      bcc = bcc ^ data[8*i +: 8];
    end
    put(bcc);
    put(CPCS_END_BYTE);
  endtask : frame
  // waits a bounded time for a start bit, samples mid-cell
  task automatic get(output logic [7:0] b);
    b = 8'hxx;
    for (int n = 0; n < 20000 && serial_tx !== 1'b0; n++) @(negedge sys_clk);
    if (serial_tx === 1'b0) begin
      repeat (CPCS_BIT_CYCLES / 2) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (CPCS_BIT_CYCLES) @(negedge sys_clk);
        b[i] = serial_tx;
      end
      repeat (CPCS_BIT_CYCLES) @(negedge sys_clk);
    end
  endtask : get
endmodule : cpcs_host
`default_nettype wire

// *** tb/cpcs_top_asserts.sv ***
/*
  checker for cpcs_top: reset values, region limits, drivers, pixel path.
  assumes it is bound to cpcs_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cpcs_top_asserts (
  input wire logic        sys_clk,             // system clock
  input wire logic        rst_n,               // async reset, active low
  input wire logic [9:0]  pixel_in,            // raw pixel
  input wire logic        pixel_in_valid,      // raw pixel valid
  input wire logic [13:0] pixel_out,           // processed pixel
  input wire logic        pixel_out_valid,     // processed pixel valid
  input wire logic        strobe_output,       // strobe level
  input wire logic        strobe_low_side_en,  // low-side driver
  input wire logic        strobe_high_side_en, // high-side driver
  input wire logic [7:0]  test_image_sel,      // image source
  input wire logic [15:0] region_first_column, // first column
  input wire logic [15:0] region_width,        // width
  input wire logic [15:0] region_height        // height
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // settings load one edge after release
  property p_rst; $rose(rst_n) |=> region_first_column == 16'h0001 && region_width == 16'h0500; endproperty
  a_rst: assert property (p_rst) else $error("reset settings wrong");
  property p_col; $past(rst_n) |-> region_first_column inside {[16'h0001:16'h04f7]}; endproperty
  a_col: assert property (p_col) else $error("first column out of range");
  property p_hgt; $past(rst_n) |-> region_height inside {[16'h0002:16'h0400]}; endproperty
  a_hgt: assert property (p_hgt) else $error("height out of range");
  property p_wid; $past(rst_n) |-> region_width inside {[16'h000a:16'h0500]}; endproperty
  a_wid: assert property (p_wid) else $error("width out of range");
  property p_img; test_image_sel <= 8'h04; endproperty
  a_img: assert property (p_img) else $error("image source out of range");
  property p_drv; !(strobe_low_side_en && strobe_high_side_en); endproperty
  a_drv: assert property (p_drv) else $error("both drivers selected");
  // pixel leaves one cycle later and never shrinks
  property p_pix; pixel_in_valid |=> pixel_out_valid && pixel_out >= {4'h0, $past(pixel_in)}; endproperty
  a_pix: assert property (p_pix) else $error("pixel path wrong");
  property p_stb; $rose(rst_n) |-> !strobe_output [*3]; endproperty
  a_stb: assert property (p_stb) else $error("strobe not low after reset");
endmodule : cpcs_top_asserts
bind cpcs_top cpcs_top_asserts u_chk (.sys_clk, .rst_n, .pixel_in, .pixel_in_valid, .pixel_out,
  .pixel_out_valid, .strobe_output, .strobe_low_side_en, .strobe_high_side_en, .test_image_sel,
  .region_first_column, .region_width, .region_height);
`default_nettype wire

// *** tb/cpcs_top_bench.sv ***
/*
  testbench for cpcs_top: table of writes, refusals, pixel path and a read.
  assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CPCS_CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module cpcs_top_bench
  import cpcs_pkg::*;
;
  typedef struct packed {logic [7:0] code; logic [7:0] desc; logic [23:0] data; logic [1:0] sel; logic [15:0] exp;} cpcs_row_type;
  localparam cpcs_row_type ROWS [4] = '{'{8'ha9, 8'h02, 24'h00000a, 2'h0, 16'h000b},
    '{8'hac, 8'h01, 24'h000021, 2'h1, 16'h0002}, '{8'h91, 8'h01, 24'h000011, 2'h2, 16'h0001},
    '{8'h99, 8'h01, 24'h000080, 2'h3, 16'h0002}};
  localparam logic [7:0] REPLY [8] = '{8'h02, 8'h98, 8'h03, 8'h0c, 8'h00, 8'h00, 8'h97, 8'h03};
  logic sys_clk = 1'b0, rst_n = 1'b0, expo = 1'b0, pix_v = 1'b0, serial_rx, serial_tx, pout_v, stb, lo, hi, dark, stamp, dyn;
  logic [9:0]  pix = 10'h000;
  logic [13:0] pout;
  logic [7:0]  img;
  logic [15:0] col, wid, line, hgt;
  int failures = 0, compares = 0, cycles = 0;
  always #20 sys_clk = ~sys_clk;
  cpcs_top dut (.sys_clk, .rst_n, .serial_rx, .serial_tx, .exposure_active(expo), .external_strobe_input(!expo),
    .pixel_in(pix), .pixel_in_valid(pix_v), .pixel_out(pout), .pixel_out_valid(pout_v), .strobe_output(stb),
    .strobe_low_side_en(lo), .strobe_high_side_en(hi), .dark_signal_constancy_en(dark), .region_stamp_en(stamp),
    .dynamic_region_en(dyn), .test_image_sel(img), .region_first_column(col), .region_width(wid),
    .region_first_line(line), .region_height(hgt));
  cpcs_host u_host (.sys_clk, .serial_rx, .serial_tx);
  // output watched by a table row
  function automatic logic [15:0] pick(input logic [1:0] s);
    case (s)
      2'h0: pick = col;
      2'h1: pick = {14'h0000, hi, lo};
      2'h2: pick = {15'h0000, dark};
      default: pick = {14'h0000, stamp, dyn};
    endcase
  endfunction : pick
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    logic [7:0] rep [8];
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CPCS_CHK(col, 16'h0001)
    foreach (ROWS[i]) begin
      u_host.frame(ROWS[i].code, ROWS[i].desc, ROWS[i].data, 8'h00);
      repeat (4) @(negedge sys_clk);
      `CPCS_CHK(pick(ROWS[i].sel), ROWS[i].exp)
    end
    // strobe follows exposure in mode one
    expo = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CPCS_CHK(stb, 1'b1)
    expo = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CPCS_CHK(stb, 1'b0)
    // both drivers, then a bad check byte, refused; column kept, width written
    u_host.frame(8'hac, 8'h01, 24'h000030, 8'h00);
    u_host.frame(8'ha9, 8'h02, 24'h000014, 8'h01);
    u_host.frame(8'hab, 8'h02, 24'h000028, 8'h00);
    repeat (4) @(negedge sys_clk);
    `CPCS_CHK({hi, lo}, 2'b10)
    `CPCS_CHK({col, wid, line, hgt}, 64'h000b002800010400)
    // gray of twelve added, then shifted left by two
    u_host.frame(8'ha5, 8'h01, 24'h000002, 8'h00);
    pix = 10'h00a;
    pix_v = 1'b1;
    @(negedge sys_clk);
    pix_v = 1'b0;
    `CPCS_CHK(pout, 14'h0058)
    // read back the gray value
    fork
      u_host.frame(8'h98, 8'h83, 24'h000000, 8'h00);
      for (int i = 0; i < 8; i++) u_host.get(rep[i]);
    join
    foreach (REPLY[i]) `CPCS_CHK(rep[i], REPLY[i])
    conclude();
  end
endmodule : cpcs_top_bench
`default_nettype wire
